/* File: test/sphy_oob_core_asserts.sv */
// Checker for the out-of-band core: timing relations seen at its ports.
// Assumes one clock domain with a synchronous, active high reset.
module sphy_oob_core_asserts
	import sphy_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic        i_link_gen2,
	input wire logic [31:0] i_rx_data,
	input wire logic [3:0]  i_rx_k,
	input wire logic        i_tx_rd_flip,
	input wire logic        o_tx_burst,
	input wire logic        o_tx_gen2,
	input wire logic        o_ssc_en,
	input wire logic        o_tx_rd_pos,
	input wire logic        o_init_oob_signal_detected_flag,
	input wire logic        o_init_oob_burst_sent_flag,
	input wire logic        o_sas_attached,
	input wire logic        o_sata_attached,
	input wire logic        o_snw_expired,
	input wire logic        o_rx_prim,
	input wire logic        o_rx_stp_prim,
	input wire logic        o_rx_native_prim
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Burst length counter
	// ----------------------------------------
	logic [7:0] hi_r;
	logic [7:0] hi_nxt;
	always_comb begin
		hi_nxt = o_tx_burst ? hi_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge i_mclk) begin
		hi_r <= i_sys_rst ? 8'h00 : hi_nxt;
	end
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// Guard on reset history: $past still sees values from inside reset
	AST_BURST_LEN: assert property ($fell(o_tx_burst) && !$past(i_sys_rst) |-> hi_r == BURST_CYC)
		else $error("burst ended at a wrong length");
	AST_BURST_MAX: assert property (hi_r <= BURST_CYC)
		else $error("burst longer than nominal");
	AST_SSC_OFF: assert property (o_ssc_en == 1'b0)
		else $error("spread spectrum enabled");
	AST_GEN1_BURST: assert property (o_tx_burst && $past(o_tx_burst) |-> !o_tx_gen2)
		else $error("burst sent at second generation rate");
	AST_GEN2_REQ: assert property (!$past(i_link_gen2) && !$past(i_sys_rst) |-> !o_tx_gen2)
		else $error("rate raised without request");
	AST_RX_PRIM: assert property (!$past(i_sys_rst) |-> o_rx_prim == ($past(i_rx_k) == 4'h1))
		else $error("primitive flag wrong");
	AST_RX_KIND: assert property (!$past(i_sys_rst) |->
		o_rx_stp_prim == ($past(i_rx_k) == 4'h1 && $past(i_rx_data[7:0]) == CHAR_K28_3) &&
		o_rx_native_prim == ($past(i_rx_k) == 4'h1 && $past(i_rx_data[7:0]) == CHAR_K28_5))
		else $error("primitive kind wrong");
	AST_RD_TRACK: assert property (!$past(i_sys_rst) |->
		o_tx_rd_pos == ($past(o_tx_rd_pos) ^ $past(i_tx_rd_flip)))
		else $error("running disparity not tracked");
	AST_ATTACH_EXCL: assert property (!(o_sas_attached && o_sata_attached))
		else $error("both partner kinds claimed");
	AST_INIT_DET_PULSE: assert property (o_init_oob_signal_detected_flag |=>
		!o_init_oob_signal_detected_flag [*8])
		else $error("detect repeated too soon");
	AST_SENT_IDLE: assert property (o_init_oob_burst_sent_flag |-> !o_tx_burst)
		else $error("sent flag during burst");
	AST_SNW_SAS: assert property (o_snw_expired |-> $past(o_sas_attached))
		else $error("window end outside link state");
endmodule : sphy_oob_core_asserts

bind sphy_oob_core sphy_oob_core_asserts u_chk (.*);

/* File: test/sphy_oob_core_tb.sv */
// Self-checking bench for the out-of-band core with one attached phy.
// Assumes the short timer values below stand in for the long defaults.
module sphy_oob_core_tb
	import sphy_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HP = 400;
	localparam int SNW = 100;
	localparam int ATO = 150;
	logic        i_mclk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_phy_rst_req = 1'b0;
	logic        i_wake_req = 1'b0;
	logic        i_sn_fail = 1'b0;
	logic        i_link_gen2 = 1'b0;
	logic        i_tx_rd_flip = 1'b0;
	logic [31:0] i_rx_data = 32'h0;
	logic [3:0]  i_rx_k = 4'h0;
	wire logic   i_squelch_on, i_rx_align, o_tx_burst, o_tx_gen2, o_ssc_en, o_tx_rd_pos;
	wire logic   o_wake_oob_signal_detected_flag, o_init_oob_signal_detected_flag;
	wire logic   o_sas_oob_signal_detected_flag, o_wake_oob_burst_sent_flag;
	wire logic   o_init_oob_burst_sent_flag, o_sas_oob_burst_sent_flag, o_snw_expired;
	wire logic   o_sas_attached, o_sata_attached, o_rx_prim, o_rx_stp_prim, o_rx_native_prim;
	wire logic [31:0] o_rx_data;
	wire logic [3:0]  o_rx_k;
	int fails, checks, n_cyc, n_rise, n_isent, n_ssent, n_wsent, n_idet, n_sdet, n_wdet;
	int n_snw, n_sas, n_sata, n_nosata, hi_run, lo_run, last_hi, last_lo;

	sphy_oob_core #(.HOTPLUG_CYC(HP), .SNW_CYC(SNW), .ALIGN_TO_CYC(ATO)) dut (.*);
	sphy_peer peer (.i_mclk(i_mclk), .o_squelch(i_squelch_on), .o_align(i_rx_align));

	initial forever #4 i_mclk = ~i_mclk;
	// ----------------------------------------
	// Event counters
	// ----------------------------------------
	always @(posedge i_mclk) begin
		n_cyc++;
		n_isent += o_init_oob_burst_sent_flag;
		n_ssent += o_sas_oob_burst_sent_flag;
		n_wsent += o_wake_oob_burst_sent_flag;
		n_idet += o_init_oob_signal_detected_flag;
		n_sdet += o_sas_oob_signal_detected_flag;
		n_wdet += o_wake_oob_signal_detected_flag;
		n_snw += o_snw_expired;
		n_sas += o_sas_attached;
		n_sata += o_sata_attached;
		n_nosata += !o_sata_attached;
		if (o_tx_burst === 1'b1) begin
			if (hi_run == 0) begin
				n_rise++;
				last_lo = lo_run;
			end
			hi_run++;
			lo_run = 0;
		end else begin
			if (hi_run != 0)
				last_hi = hi_run;
			hi_run = 0;
			lo_run++;
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : step
	task automatic wait_cnt(input string what, ref int c, input int tgt, input int lim);
		for (int i = 0; i < lim && c < tgt; i++)
			step(1);
		if (c < tgt) begin
			fails++;
			$display("mismatch %s expected event seen timeout", what);
			give_verdict();
		end
	endtask : wait_cnt
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_first_init();
		check("ssc", o_ssc_en, 1'b0);
		wait_cnt("init sent", n_isent, 1, 600);
		check("burst count", n_rise, TX_REPS);
		check("burst length", last_hi, BURST_CYC);
		check("init gap", last_lo, INIT_GAP_CYC);
	endtask : t_first_init
	task automatic t_sas_link();
		int c0;
		peer.send_oob(30, 6);
		check("init detects", n_idet, 1);
		peer.send_oob(SAS_GAP_CYC, 6);
		wait_cnt("sas sent", n_ssent, 1, 400);
		check("sas gap", last_lo, SAS_GAP_CYC);
		wait_cnt("sas link", n_sas, 1, 500);
		check("sas detects", n_sdet, 1);
		wait_cnt("window", n_snw, n_snw + 1, SNW + 5);
		c0 = n_cyc;
		wait_cnt("window", n_snw, n_snw + 1, SNW + 5);
		check("window length", n_cyc - c0, SNW);
		i_sn_fail = 1'b1;
		step(1);
		i_sn_fail = 1'b0;
		c0 = n_cyc;
		wait_cnt("retry", n_rise, n_rise + 1, 3 * HP + 50);
		check("holdoff", (n_cyc - c0) >= HP, 1'b1);
		check("sas dropped", o_sas_attached, 1'b0);
		wait_cnt("init resent", n_isent, n_isent + 1, 400);
	endtask : t_sas_link
	task automatic t_sata_link();
		int c0;
		int d0;
		peer.align_on = 1'b1;
		peer.send_oob(60, 6);
		wait_cnt("sas sent", n_ssent, n_ssent + 1, 500);
		c0 = n_cyc;
		wait_cnt("sata link", n_sata, 1, 600);
		check("silence", (n_cyc - c0) inside {[SAS_TO_CYC - 3 : SAS_TO_CYC + 5]}, 1'b1);
		d0 = n_idet + n_sdet + n_wdet;
		peer.send_oob(70, 6);
		step(4);
		check("reject", n_idet + n_sdet + n_wdet, d0);
		peer.send_oob(12, 6);
		step(4);
		check("wake detect", n_wdet, 1);
		i_wake_req = 1'b1;
		wait_cnt("wake start", n_rise, n_rise + 1, 20);
		i_wake_req = 1'b0;
		wait_cnt("wake sent", n_wsent, 1, 200);
		check("wake gap", last_lo, WAKE_GAP_CYC);
		i_link_gen2 = 1'b1;
		step(3);
		check("rate", o_tx_gen2, 1'b1);
		i_link_gen2 = 1'b0;
		t_framing();
		t_disparity();
	endtask : t_sata_link
	task automatic t_align_timeout();
		int c0;
		// The alignment flag is sticky per state, so the timeout needs a fresh entry
		peer.align_on = 1'b0;
		peer.send_oob(60, 6);
		peer.send_oob(60, 6);
		wait_cnt("sas resent", n_ssent, n_ssent + 1, 900);
		wait_cnt("sata again", n_sata, n_sata + 1, 600);
		c0 = n_cyc;
		wait_cnt("align timeout", n_nosata, n_nosata + 1, ATO + 20);
		check("align wait", n_cyc - c0, ATO);
		check("sata dropped", o_sata_attached, 1'b0);
	endtask : t_align_timeout
	task automatic t_framing();
		logic [38:0] tv [4] = '{{32'h4A4A_4ABC, 4'h1, 3'b101}, {32'h4A4A_4A7C, 4'h1, 3'b110},
			{32'h0000_00BC, 4'h0, 3'b000}, {32'h0000_BCBC, 4'h3, 3'b000}};
		for (int i = 0; i < 4; i++) begin
			{i_rx_data, i_rx_k} = tv[i][38:3];
			step(1);
			check("rx data", o_rx_data, tv[i][38:7]);
			check("rx k", o_rx_k, tv[i][6:3]);
			check("rx prim", o_rx_prim, tv[i][2]);
			check("rx stp", o_rx_stp_prim, tv[i][1]);
			check("rx native", o_rx_native_prim, tv[i][0]);
		end
	endtask : t_framing
	task automatic t_disparity();
		logic p;
		p = o_tx_rd_pos;
		i_tx_rd_flip = 1'b1;
		step(1);
		i_tx_rd_flip = 1'b0;
		check("disparity", o_tx_rd_pos, !p);
		step(1);
		check("disparity hold", o_tx_rd_pos, !p);
	endtask : t_disparity

	initial begin
		repeat (6) @(posedge i_mclk);
		#1 i_sys_rst = 1'b0;
		t_first_init();
		t_sas_link();
		t_sata_link();
		t_align_timeout();
		give_verdict();
	end
endmodule : sphy_oob_core_tb

/* File: test/sphy_peer.sv */
// Behavioural attached phy: emits out-of-band envelopes and ALIGN presence.
// Assumes the bench calls send_oob while the link is otherwise quiet.
module sphy_peer
	import sphy_pkg::*;
(
	input  wire logic i_mclk,
	output logic      o_squelch,
	output logic      o_align
);
	timeunit 1ns;
	timeprecision 100ps;
	logic align_on = 1'b0;
	initial o_squelch = 1'b0;
	assign o_align = align_on;
	// ----------------------------------------
	// Signal generation
	// ----------------------------------------
	// Only the envelope is modelled; the ALIGN count inside does not matter
	task automatic send_oob(input int gap, input int reps);
		for (int i = 0; i < reps; i++) begin
			@(posedge i_mclk) #1 o_squelch = 1'b1;
			repeat (BURST_CYC) @(posedge i_mclk);
			#1 o_squelch = 1'b0;
			repeat (gap - 1) @(posedge i_mclk);
		end
	endtask : send_oob
endmodule : sphy_peer

/* File: verilog/sphy_oob_core.sv */
// Out-of-band signal generator, detector, reset handshake and dword framing for one phy.
// Assumes a squelch envelope and a decoded receive dword, both synchronous to i_mclk.
// Operation
// - Transmitter never spreads its clock; expander receiver tolerates spread input.
// - Received SATA data is retimed onto the local clock before forwarding.
// - Data bytes travel as 8b10b data characters; others are control characters.
// - Four characters form a dword; primitive is control first, then three data.
// - Tunnelled SATA primitives open with K28.3; all others with K28.5.
// - Each link keeps its own running disparity; re-encode for the outgoing link.
// - Signals are 160 UI bursts plus idle gaps; gap length alone tells the type.
// - Send six repetitions; report detection after four received repetitions.
// - Wake gap nominal 106.7 ns, accepted between 55 ns and 175 ns.
// - Init and reset share one pattern with a nominal 320 ns gap.
// - Received signals are never forwarded; each link runs its own reset.
// - Detector flags each recognised type; generator flags each sent six-burst.
// - Bursts go out at first generation rate, never faster than slowest rate; the first burst cycle follows i_link_gen2.
// - Detection depends on gap durations only, at any rate; burst length is not checked.
// - SAS-identify detector rejects spacings below 175 ns or above 525 ns.
// - SAS-identify detector accepts every spacing from 304 ns to 336 ns.
// - SAS-identify transmit spacing nominal 320 ns, within 310.4 to 329.6 ns.
// - Hot-plug retry timer, nominal 100 ms, allowed between 10 and 500 ms.
// - A rate change completes within 320 ns.
// - Speed negotiation window lasts 4096 times 40 first generation UI.
// - ALIGN detect timeout is at most 880 us.
// - Send SAS-identify during calibration to announce a SAS phy.
// - Init reply or 3.5 us silence after SAS-identify means a SATA partner.
// - Resend init whenever hot-plug timeout expires without init received.
// - After failed speed negotiation, wait one hot-plug timeout before retrying.
module sphy_oob_core
	import sphy_pkg::*;
#(
	parameter int HOTPLUG_CYC  = HOTPLUG_CYC_DEF,
	parameter int SNW_CYC      = SNW_CYC_DEF,
	parameter int ALIGN_TO_CYC = ALIGN_TO_CYC_DEF
) (
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_squelch_on,
	input  wire logic        i_phy_rst_req,
	input  wire logic        i_wake_req,
	input  wire logic        i_sn_fail,
	input  wire logic        i_link_gen2,
	input  wire logic        i_rx_align,
	input  wire logic [31:0] i_rx_data,
	input  wire logic [3:0]  i_rx_k,
	input  wire logic        i_tx_rd_flip,
	output logic             o_tx_burst,
	output logic             o_tx_gen2,
	output logic             o_ssc_en,
	output logic             o_tx_rd_pos,
	output logic             o_wake_oob_signal_detected_flag,
	output logic             o_init_oob_signal_detected_flag,
	output logic             o_sas_oob_signal_detected_flag,
	output logic             o_wake_oob_burst_sent_flag,
	output logic             o_init_oob_burst_sent_flag,
	output logic             o_sas_oob_burst_sent_flag,
	output logic             o_sas_attached,
	output logic             o_sata_attached,
	output logic             o_snw_expired,
	output logic [31:0]      o_rx_data,
	output logic [3:0]       o_rx_k,
	output logic             o_rx_prim,
	output logic             o_rx_stp_prim,
	output logic             o_rx_native_prim
);
	// ---------------------------------------------------------------
	// Detector: squelch-gated gap timing
	// ---------------------------------------------------------------
	logic       sq_prev_r, sq_prev_nxt;
	logic       in_gap_r, in_gap_nxt;
	logic [7:0] gap_cnt_r, gap_cnt_nxt;
	logic [2:0] rep_cnt_r, rep_cnt_nxt;
	sphy_oob_t  rep_type_r, rep_type_nxt;
	logic [2:0] det_r, det_nxt;
	sphy_oob_t  gap_type;

	always_comb begin
		sq_prev_nxt  = i_squelch_on;
		in_gap_nxt   = in_gap_r;
		gap_cnt_nxt  = gap_cnt_r;
		rep_cnt_nxt  = rep_cnt_r;
		rep_type_nxt = rep_type_r;
		det_nxt      = 3'h0;
		gap_type     = SPHY_OOB_NONE;
		// Only time matters, so any ALIGN rate that fills the envelope works
		if (sq_prev_r && !i_squelch_on) begin
			in_gap_nxt  = 1'b1;
			gap_cnt_nxt = 8'h01;
		end else if (in_gap_r && !i_squelch_on) begin
			if (gap_cnt_r != GAP_SAT)
				gap_cnt_nxt = gap_cnt_r + 8'h01;
			else
				rep_cnt_nxt = 3'h0;
		end else if (in_gap_r && i_squelch_on) begin
			in_gap_nxt = 1'b0;
			// Identify window overlaps the init window and wins there
			if (gap_cnt_r >= SAS_MIN_CYC && gap_cnt_r <= SAS_MAX_CYC)
				gap_type = SPHY_OOB_SAS;
			else if (gap_cnt_r >= INIT_MIN_CYC && gap_cnt_r <= INIT_MAX_CYC)
				gap_type = SPHY_OOB_INIT;
			else if (gap_cnt_r >= WAKE_MIN_CYC && gap_cnt_r <= WAKE_MAX_CYC)
				gap_type = SPHY_OOB_WAKE;
			if (gap_type == SPHY_OOB_NONE) begin
				rep_cnt_nxt = 3'h0;
			end else if (gap_type == rep_type_r && rep_cnt_r != 3'h0) begin
				rep_cnt_nxt = rep_cnt_r + 3'h1;
			end else begin
				rep_cnt_nxt  = 3'h1;
				rep_type_nxt = gap_type;
			end
			if (rep_cnt_nxt == RX_REPS) begin
				rep_cnt_nxt = 3'h0;
				det_nxt[gap_type - 2'h1] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			sq_prev_r  <= 1'b0;
			in_gap_r   <= 1'b0;
			gap_cnt_r  <= 8'h00;
			rep_cnt_r  <= 3'h0;
			rep_type_r <= SPHY_OOB_NONE;
			det_r      <= 3'h0;
		end else begin
			sq_prev_r  <= sq_prev_nxt;
			in_gap_r   <= in_gap_nxt;
			gap_cnt_r  <= gap_cnt_nxt;
			rep_cnt_r  <= rep_cnt_nxt;
			rep_type_r <= rep_type_nxt;
			det_r      <= det_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Generator, reset handshake and timers
	// ---------------------------------------------------------------
	sphy_state_t st_r, st_nxt;
	logic        gen_busy_r, gen_busy_nxt;
	logic        gen_burst_r, gen_burst_nxt;
	sphy_oob_t   gen_type_r, gen_type_nxt;
	logic [2:0]  gen_rep_r, gen_rep_nxt;
	logic [7:0]  gen_cnt_r, gen_cnt_nxt;
	logic [2:0]  sent_r, sent_nxt;
	logic        seen_init_r, seen_init_nxt;
	logic        seen_sas_r, seen_sas_nxt;
	logic        aligned_r, aligned_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic        snw_r, snw_nxt;
	logic        gen2_r, gen2_nxt;
	logic        rd_pos_r, rd_pos_nxt;
	logic        gen_start;
	sphy_oob_t   gen_req;
	logic [7:0]  gen_gap;

	always_comb begin
		st_nxt        = st_r;
		gen_busy_nxt  = gen_busy_r;
		gen_burst_nxt = gen_burst_r;
		gen_type_nxt  = gen_type_r;
		gen_rep_nxt   = gen_rep_r;
		gen_cnt_nxt   = gen_cnt_r;
		sent_nxt      = 3'h0;
		seen_init_nxt = seen_init_r;
		seen_sas_nxt  = seen_sas_r | det_r[2];
		aligned_nxt   = aligned_r | i_rx_align;
		tmr_nxt       = tmr_r + 32'h1;
		snw_nxt       = 1'b0;
		gen_start     = 1'b0;
		gen_req       = SPHY_OOB_NONE;
		// Identify and init share the 320 ns spacing, inside the transmit limits
		gen_gap       = (gen_type_r == SPHY_OOB_WAKE) ? WAKE_GAP_CYC :
		                (gen_type_r == SPHY_OOB_SAS) ? SAS_GAP_CYC : INIT_GAP_CYC;
		// Rate drops to first generation one cycle after a burst sequence starts; link rate applies whenever the generator is idle
		gen2_nxt      = i_link_gen2 && !gen_busy_r;
		rd_pos_nxt    = rd_pos_r ^ i_tx_rd_flip;

		// Signals are generated locally only, never relayed from the receiver
		unique case (st_r)
			SPHY_ST_RESET: begin
				seen_init_nxt = seen_init_r | det_r[1];
				// No fresh set once the sent flag moves the state on; it would leak out
				gen_start     = !gen_busy_r && !i_phy_rst_req && !sent_r[1];
				gen_req       = SPHY_OOB_INIT;
				if (sent_r[1] && !i_phy_rst_req)
					st_nxt = (seen_init_r || det_r[1]) ? SPHY_ST_SEND_SAS : SPHY_ST_AWAIT_COM;
			end
			SPHY_ST_AWAIT_COM: begin
				if (det_r[1] || det_r[2])
					st_nxt = SPHY_ST_SEND_SAS;
				else if (tmr_r >= 32'(HOTPLUG_CYC - 1))
					st_nxt = SPHY_ST_RESET;
			end
			SPHY_ST_SEND_SAS: begin
				gen_start = !gen_busy_r && !sent_r[2];
				gen_req   = SPHY_OOB_SAS;
				if (sent_r[2])
					st_nxt = (seen_sas_r || det_r[2]) ? SPHY_ST_SAS_LINK : SPHY_ST_AWAIT_SAS;
			end
			SPHY_ST_AWAIT_SAS: begin
				if (det_r[2])
					st_nxt = SPHY_ST_SAS_LINK;
				else if (det_r[1] || tmr_r >= SAS_TO_CYC - 32'h1)
					st_nxt = SPHY_ST_SATA_LINK;
			end
			SPHY_ST_SAS_LINK: begin
				if (tmr_r >= 32'(SNW_CYC - 1)) begin
					tmr_nxt = 32'h0;
					snw_nxt = 1'b1;
				end
				if (i_sn_fail)
					st_nxt = SPHY_ST_HOLDOFF;
				else if (det_r[1])
					st_nxt = SPHY_ST_RESET;
			end
			SPHY_ST_HOLDOFF: begin
				if (tmr_r >= 32'(HOTPLUG_CYC - 1))
					st_nxt = SPHY_ST_AWAIT_COM;
			end
			SPHY_ST_SATA_LINK: begin
				gen_start = i_wake_req && !gen_busy_r;
				gen_req   = SPHY_OOB_WAKE;
				if (det_r[1] || (!aligned_r && tmr_r >= 32'(ALIGN_TO_CYC - 1)))
					st_nxt = SPHY_ST_RESET;
			end
		endcase
		if (i_phy_rst_req)
			st_nxt = SPHY_ST_RESET;
		if (st_nxt != st_r) begin
			tmr_nxt     = 32'h0;
			// An ALIGN in the entry cycle still counts
			aligned_nxt = i_rx_align;
			if (st_nxt == SPHY_ST_RESET) begin
				seen_init_nxt = 1'b0;
				seen_sas_nxt  = 1'b0;
			end
		end

		// Six bursts with their gaps, then a one-cycle sent flag
		if (gen_start) begin
			gen_busy_nxt  = 1'b1;
			gen_burst_nxt = 1'b1;
			gen_type_nxt  = gen_req;
			gen_rep_nxt   = 3'h0;
			gen_cnt_nxt   = 8'h01;
		end else if (gen_busy_r) begin
			gen_cnt_nxt = gen_cnt_r + 8'h01;
			if (gen_burst_r && gen_cnt_r == BURST_CYC) begin
				gen_burst_nxt = 1'b0;
				gen_cnt_nxt   = 8'h01;
			end else if (!gen_burst_r && gen_cnt_r == gen_gap) begin
				gen_cnt_nxt = 8'h01;
				gen_rep_nxt = gen_rep_r + 3'h1;
				if (gen_rep_r == TX_REPS - 3'h1) begin
					gen_busy_nxt = 1'b0;
					sent_nxt[gen_type_r - 2'h1] = 1'b1;
				end else begin
					gen_burst_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st_r        <= SPHY_ST_RESET;
			gen_busy_r  <= 1'b0;
			gen_burst_r <= 1'b0;
			gen_type_r  <= SPHY_OOB_NONE;
			gen_rep_r   <= 3'h0;
			gen_cnt_r   <= 8'h00;
			sent_r      <= 3'h0;
			seen_init_r <= 1'b0;
			seen_sas_r  <= 1'b0;
			aligned_r   <= 1'b0;
			tmr_r       <= 32'h0;
			snw_r       <= 1'b0;
			gen2_r      <= 1'b0;
			rd_pos_r    <= 1'b0;
		end else begin
			st_r        <= st_nxt;
			gen_busy_r  <= gen_busy_nxt;
			gen_burst_r <= gen_burst_nxt;
			gen_type_r  <= gen_type_nxt;
			gen_rep_r   <= gen_rep_nxt;
			gen_cnt_r   <= gen_cnt_nxt;
			sent_r      <= sent_nxt;
			seen_init_r <= seen_init_nxt;
			seen_sas_r  <= seen_sas_nxt;
			aligned_r   <= aligned_nxt;
			tmr_r       <= tmr_nxt;
			snw_r       <= snw_nxt;
			gen2_r      <= gen2_nxt;
			rd_pos_r    <= rd_pos_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Receive dword retiming and primitive classification
	// ---------------------------------------------------------------
	logic [31:0] rx_data_r, rx_data_nxt;
	logic [3:0]  rx_k_r, rx_k_nxt;
	logic [2:0]  prim_r, prim_nxt;

	always_comb begin
		rx_data_nxt = i_rx_data;
		rx_k_nxt    = i_rx_k;
		prim_nxt    = 3'h0;
		// Byte 0 is the first character of the dword
		if (i_rx_k == 4'h1) begin
			prim_nxt[0] = 1'b1;
			prim_nxt[1] = (i_rx_data[7:0] == CHAR_K28_3);
			prim_nxt[2] = (i_rx_data[7:0] == CHAR_K28_5);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rx_data_r <= 32'h0;
			rx_k_r    <= 4'h0;
			prim_r    <= 3'h0;
		end else begin
			rx_data_r <= rx_data_nxt;
			rx_k_r    <= rx_k_nxt;
			prim_r    <= prim_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs from flip-flops, except o_ssc_en tied low and the attached flags decoded from st_r
	// ---------------------------------------------------------------
	assign o_tx_burst                      = gen_burst_r;
	assign o_tx_gen2                       = gen2_r;
	assign o_ssc_en                        = 1'b0;
	assign o_tx_rd_pos                     = rd_pos_r;
	assign o_wake_oob_signal_detected_flag = det_r[0];
	assign o_init_oob_signal_detected_flag = det_r[1];
	assign o_sas_oob_signal_detected_flag  = det_r[2];
	assign o_wake_oob_burst_sent_flag      = sent_r[0];
	assign o_init_oob_burst_sent_flag      = sent_r[1];
	assign o_sas_oob_burst_sent_flag       = sent_r[2];
	assign o_sas_attached                  = (st_r == SPHY_ST_SAS_LINK);
	assign o_sata_attached                 = (st_r == SPHY_ST_SATA_LINK);
	assign o_snw_expired                   = snw_r;
	assign o_rx_data                       = rx_data_r;
	assign o_rx_k                          = rx_k_r;
	assign o_rx_prim                       = prim_r[0];
	assign o_rx_stp_prim                   = prim_r[1];
	assign o_rx_native_prim                = prim_r[2];
endmodule : sphy_oob_core

/* File: verilog/sphy_pkg.sv */
// Package for the serial phy out-of-band and line coding block.
// Assumes a single 125 MHz clock; all times are converted to cycles here.
package sphy_pkg;
	// ---------------------------------------------------------------
	// Clock and signal times
	// ---------------------------------------------------------------
	localparam longint CLK_PS          = 8000;
	localparam longint BURST_PS        = 106700;
	localparam longint WAKE_GAP_PS     = 106700;
	localparam longint WAKE_MIN_PS     = 55000;
	localparam longint WAKE_MAX_PS     = 175000;
	localparam longint INIT_GAP_PS     = 320000;
	localparam longint INIT_MIN_PS     = 175000;
	localparam longint INIT_MAX_PS     = 525000;
	localparam longint SAS_GAP_PS      = 320000;
	localparam longint SAS_ON_MIN_PS   = 304000;
	localparam longint SAS_ON_MAX_PS   = 336000;
	localparam longint SAS_TO_PS       = 3500000;
	localparam longint HOTPLUG_PS      = 64'd100000000000;
	localparam longint UI_G1_FS        = 666667;
	localparam longint SNW_UI_MULT     = 4096 * 40;
	localparam longint ALIGN_TO_PS     = 64'd880000000;

	// ---------------------------------------------------------------
	// Cycle counts (wake and init least times round up, longest round down; SAS-identify the reverse)
	// ---------------------------------------------------------------
	localparam logic [7:0] BURST_CYC    = 8'(BURST_PS / CLK_PS);
	localparam logic [7:0] WAKE_GAP_CYC = 8'(WAKE_GAP_PS / CLK_PS);
	localparam logic [7:0] INIT_GAP_CYC = 8'(INIT_GAP_PS / CLK_PS);
	localparam logic [7:0] SAS_GAP_CYC  = 8'(SAS_GAP_PS / CLK_PS);
	localparam logic [7:0] WAKE_MIN_CYC = 8'((WAKE_MIN_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] WAKE_MAX_CYC = 8'(WAKE_MAX_PS / CLK_PS);
	localparam logic [7:0] INIT_MIN_CYC = 8'((INIT_MIN_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] INIT_MAX_CYC = 8'(INIT_MAX_PS / CLK_PS);
	localparam logic [7:0] SAS_MIN_CYC  = 8'(SAS_ON_MIN_PS / CLK_PS);
	localparam logic [7:0] SAS_MAX_CYC  = 8'((SAS_ON_MAX_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [31:0] SAS_TO_CYC  = 32'(SAS_TO_PS / CLK_PS);
	localparam int HOTPLUG_CYC_DEF      = int'(HOTPLUG_PS / CLK_PS);
	localparam int SNW_CYC_DEF          = int'((UI_G1_FS * SNW_UI_MULT) / (CLK_PS * 1000));
	localparam int ALIGN_TO_CYC_DEF     = int'(ALIGN_TO_PS / CLK_PS);

	// ---------------------------------------------------------------
	// Signal repetition and characters
	// ---------------------------------------------------------------
	localparam logic [2:0] TX_REPS      = 3'd6;
	localparam logic [2:0] RX_REPS      = 3'd4;
	localparam logic [7:0] GAP_SAT      = 8'hFF;
	localparam logic [7:0] CHAR_K28_3   = 8'h7C;
	localparam logic [7:0] CHAR_K28_5   = 8'hBC;

	typedef enum logic [1:0] {
		SPHY_OOB_NONE = 2'h0,
		SPHY_OOB_WAKE = 2'h1,
		SPHY_OOB_INIT = 2'h2,
		SPHY_OOB_SAS  = 2'h3
	} sphy_oob_t;

	typedef enum logic [6:0] {
		SPHY_ST_RESET     = 7'h01,
		SPHY_ST_AWAIT_COM = 7'h02,
		SPHY_ST_SEND_SAS  = 7'h04,
		SPHY_ST_AWAIT_SAS = 7'h08,
		SPHY_ST_SAS_LINK  = 7'h10,
		SPHY_ST_HOLDOFF   = 7'h20,
		SPHY_ST_SATA_LINK = 7'h40
	} sphy_state_t;
endpackage : sphy_pkg
